//--- common/difd_consts.svh
// Function codes, timing and field constants for the input function decoder.
// Assumes inclusion by bare name from design files.
`ifndef DIFD_CONSTS_SVH
`define DIFD_CONSTS_SVH
`define DIFD_NUM_TERM 7
`define DIFD_FN_W 8
`define DIFD_FREQ_W 16
`define DIFD_FN_RAMP_HOLD 8'h0A
`define DIFD_FN_UP 8'h10
`define DIFD_FN_DOWN 8'h11
`define DIFD_FN_PID_CANCEL 8'h19
`define DIFD_FN_ACC_SEL1 8'h07
`define DIFD_FN_ACC_SEL2 8'h1A
`define DIFD_FN_LOCKOUT 8'h1B
`define DIFD_FN_SAMPLE_HOLD 8'h1E
`define DIFD_FN_EXT_FAULT_LO 8'h20
`define DIFD_FN_EXT_FAULT_HI 8'h2F
`define DIFD_FN_INT_RESET 8'h30
`define DIFD_FN_INT_HOLD 8'h31
`define DIFD_FN_SPEED_SEL1 8'h03
`define DIFD_FN_SPEED_SEL2 8'h04
`define DIFD_FN_SPEED_SEL3 8'h05
`define DIFD_FN_SPEED_SEL4 8'h32
`define DIFD_FN_SFS_CANCEL 8'h34
`define DIFD_FN_PID_INVERT 8'h35
`define DIFD_FN_FWD_RUN 8'h40
`define DIFD_FN_REV_RUN 8'h41
`define DIFD_FN_RUN2 8'h42
`define DIFD_FN_DIR2 8'h43
`define DIFD_FN_OFFSET1 8'h44
`define DIFD_FN_OFFSET2 8'h45
`define DIFD_FN_OFFSET3 8'h46
`define DIFD_FN_DC_BRAKE 8'h60
`define DIFD_FN_SEARCH1 8'h61
`define DIFD_FN_SEARCH2 8'h62
`define DIFD_FN_UPDN2_UP 8'h75
`define DIFD_FN_UPDN2_DN 8'h76
`define DIFD_EF_POL_BIT 0
`define DIFD_EF_RUNONLY_BIT 1
`define DIFD_EF_STOP_LSB 2
`define DIFD_CLK_HZ 20000000
`define DIFD_SH_MIN_MS 100
`define DIFD_SH_CYCLES ((`DIFD_CLK_HZ / 1000) * `DIFD_SH_MIN_MS)
`define DIFD_CNT_W 22
`endif

//--- common/difd_pkg.sv
// Types shared by the input function decoder files.
// Assumes the constants header is compiled alongside.
package difd_pkg;
   typedef enum logic [1:0] {
      DIFD_STOP_RAMP = 2'b00,
      DIFD_STOP_COAST = 2'b01,
      DIFD_STOP_FAST = 2'b10,
      DIFD_STOP_ALARM = 2'b11
   } difd_stop_t;
   typedef enum logic [1:0] {
      DIFD_SH_IDLE = 2'b00,
      DIFD_SH_TIMING = 2'b01,
      DIFD_SH_DONE = 2'b11
   } difd_sh_state_t;
endpackage

//--- hw/difd_sample_hold.sv
// Sample/hold of the analog reference after a minimum held time.
// Assumes a synchronised sample request and a steady analog word.
`timescale 1ns/10ps
`include "difd_consts.svh"
module difd_sample_hold #(
   parameter logic [`DIFD_CNT_W-1:0] HOLD_CYCLES = `DIFD_CNT_W'(`DIFD_SH_CYCLES)
) (
   // Clock and reset
   input wire logic clock,
   input wire logic sys_rst,
   // Request and data
   input wire logic req,
   input wire logic [`DIFD_FREQ_W-1:0] analog_in,
   output logic [`DIFD_FREQ_W-1:0] held_q,
   output logic held_valid_q
);
   difd_pkg::difd_sh_state_t state_q, state_d;
   logic [`DIFD_CNT_W-1:0] cnt_q, cnt_d;
   logic [`DIFD_FREQ_W-1:0] held_d;
   logic held_valid_d;

   always_comb begin
      state_d = state_q;
      cnt_d = cnt_q;
      held_d = held_q;
      held_valid_d = held_valid_q;
      case (state_q)
         difd_pkg::DIFD_SH_IDLE: begin
            cnt_d = '0;
            if (req) begin
               state_d = difd_pkg::DIFD_SH_TIMING;
            end
         end
         difd_pkg::DIFD_SH_TIMING: begin
            if (!req) begin
               state_d = difd_pkg::DIFD_SH_IDLE;
            end else if (cnt_q >= HOLD_CYCLES - `DIFD_CNT_W'(2)) begin
               held_d = analog_in;
               held_valid_d = 1'b1;
               state_d = difd_pkg::DIFD_SH_DONE;
            end else begin
               cnt_d = cnt_q + `DIFD_CNT_W'(1);
            end
         end
         difd_pkg::DIFD_SH_DONE: begin
            if (!req) begin
               state_d = difd_pkg::DIFD_SH_IDLE;
            end
         end
         default: state_d = difd_pkg::DIFD_SH_IDLE;
      endcase
   end

   // Reset stands in for power loss: sample is lost
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         state_q <= difd_pkg::DIFD_SH_IDLE;
         cnt_q <= '0;
         held_q <= '0;
         held_valid_q <= 1'b0;
      end else begin
         state_q <= state_d;
         cnt_q <= cnt_d;
         held_q <= held_d;
         held_valid_q <= held_valid_d;
      end
   end
endmodule // difd_sample_hold

//--- hw/difd_sync.sv
// Two-stage synchroniser for the terminal inputs.
// Assumes terminals are asynchronous contacts.
`timescale 1ns/10ps
`include "difd_consts.svh"
module difd_sync (
   // Clock and reset
   input wire logic clock,
   input wire logic sys_rst,
   // Raw and synchronised terminals
   input wire logic [`DIFD_NUM_TERM-1:0] raw_in,
   output logic [`DIFD_NUM_TERM-1:0] sync_q
);
   logic [`DIFD_NUM_TERM-1:0] meta_q;
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         meta_q <= '0;
         sync_q <= '0;
      end else begin
         meta_q <= raw_in;
         sync_q <= meta_q;
      end
   end
endmodule // difd_sync

//--- hw/difd_decoder.sv
// Multi-function digital input decoder: maps terminal functions to actions.
// Assumes terminal levels are raw contacts (1 = closed) and settings are static.
`timescale 1ns/10ps
`include "difd_consts.svh"
module difd_decoder #(
   parameter logic [`DIFD_CNT_W-1:0] HOLD_CYCLES = `DIFD_CNT_W'(`DIFD_SH_CYCLES)
) (
   // Clock and reset
   input wire logic clock,
   input wire logic sys_rst,

   // Terminals and their function settings
   input wire logic [`DIFD_NUM_TERM-1:0] term_in,
   input wire logic [`DIFD_NUM_TERM*`DIFD_FN_W-1:0] input_function_select,

   // Drive status and settings
   input wire logic drive_running,
   input wire logic pid_mode_select,
   input wire logic jog_cmd,
   input wire logic search_method_select,
   input wire logic param_write_req,
   input wire logic [`DIFD_FREQ_W-1:0] analog_ref,
   input wire logic [`DIFD_FREQ_W-1:0] base_ref,
   input wire logic [3*`DIFD_FREQ_W-1:0] offset_frequency_values,

   // Decoded actions
   output logic param_write_en_q,
   output logic config_conflict_error_q,
   output logic ext_fault_q,
   output logic ext_alarm_q,
   output logic [3:0] external_fault_indication_q,
   output logic [1:0] fault_stop_q,
   output logic pid_enable_q,
   output logic integ_reset_q,
   output logic integ_hold_q,
   output logic soft_starter_bypass_q,
   output logic pid_invert_q,
   output logic [1:0] ramp_set_q,
   output logic [3:0] preset_speed_q,
   output logic run_cmd_q,
   output logic reverse_q,
   output logic dc_brake_q,
   output logic search_from_max_q,
   output logic search_from_ref_q,
   output logic [`DIFD_FREQ_W-1:0] freq_ref_q
);
   logic [`DIFD_NUM_TERM-1:0] term_s;
   logic [`DIFD_FREQ_W-1:0] held_ref;
   logic held_valid;

   // Asynchronous contacts
   difd_sync u_sync (
      .clock(clock),
      .sys_rst(sys_rst),
      .raw_in(term_in),
      .sync_q(term_s)
   );

   // Function code of a terminal
   function automatic logic [`DIFD_FN_W-1:0] fn_of(input logic [`DIFD_NUM_TERM*`DIFD_FN_W-1:0] sel, input int t);
      fn_of = sel[t*`DIFD_FN_W +: `DIFD_FN_W];
   endfunction

   // Any terminal assigned this code
   function automatic logic assigned(input logic [`DIFD_NUM_TERM*`DIFD_FN_W-1:0] sel,
                                     input logic [`DIFD_FN_W-1:0] code);
      assigned = 1'b0;
      for (int t = 0; t < `DIFD_NUM_TERM; t++) begin
         if (fn_of(sel, t) == code) begin
            assigned = 1'b1;
         end
      end
   endfunction

   // Any closed terminal carrying this code
   function automatic logic active(input logic [`DIFD_NUM_TERM*`DIFD_FN_W-1:0] sel,
                                   input logic [`DIFD_NUM_TERM-1:0] lvl, input logic [`DIFD_FN_W-1:0] code);
      active = 1'b0;
      for (int t = 0; t < `DIFD_NUM_TERM; t++) begin
         if (fn_of(sel, t) == code && lvl[t]) begin
            active = 1'b1;
         end
      end
   endfunction

   logic sh_assigned;
   assign sh_assigned = assigned(input_function_select, `DIFD_FN_SAMPLE_HOLD);

   // Held-time qualified sampling
   difd_sample_hold #(
      .HOLD_CYCLES(HOLD_CYCLES)
   ) u_sh (
      .clock(clock),
      .sys_rst(sys_rst),
      .req(active(input_function_select, term_s, `DIFD_FN_SAMPLE_HOLD)),
      .analog_in(analog_ref),
      .held_q(held_ref),
      .held_valid_q(held_valid)
   );

   logic param_write_en_d, config_conflict_error_d, ext_fault_d, ext_alarm_d;
   logic [3:0] external_fault_indication_d;
   logic [1:0] fault_stop_d;
   logic pid_enable_d, integ_reset_d, integ_hold_d, soft_starter_bypass_d, pid_invert_d;
   logic [1:0] ramp_set_d;
   logic [3:0] preset_speed_d;
   logic run_cmd_d, reverse_d, dc_brake_d, search_from_max_d, search_from_ref_d;
   logic [`DIFD_FREQ_W-1:0] freq_ref_d;

   always_comb begin
      logic [`DIFD_FN_W-1:0] code;
      logic trip;
      logic fwd, rev;
      logic [`DIFD_FREQ_W-1:0] ref_sum;

      code = '0;
      trip = 1'b0;
      fwd = 1'b0;
      rev = 1'b0;
      ref_sum = '0;

      // Lockout: any open lockout contact blocks writes
      param_write_en_d = param_write_req &
         !active(input_function_select, ~term_s, `DIFD_FN_LOCKOUT);
      config_conflict_error_d = (sh_assigned &
         (assigned(input_function_select, `DIFD_FN_RAMP_HOLD) |
          assigned(input_function_select, `DIFD_FN_UP) |
          assigned(input_function_select, `DIFD_FN_DOWN) |
          assigned(input_function_select, `DIFD_FN_OFFSET1) |
          assigned(input_function_select, `DIFD_FN_OFFSET2) |
          assigned(input_function_select, `DIFD_FN_OFFSET3) |
          assigned(input_function_select, `DIFD_FN_UPDN2_UP) |
          assigned(input_function_select, `DIFD_FN_UPDN2_DN)))
         | ((assigned(input_function_select, `DIFD_FN_FWD_RUN) |
             assigned(input_function_select, `DIFD_FN_REV_RUN)) &
            (assigned(input_function_select, `DIFD_FN_RUN2) |
             assigned(input_function_select, `DIFD_FN_DIR2)))
         | (assigned(input_function_select, `DIFD_FN_SEARCH1) &
            assigned(input_function_select, `DIFD_FN_SEARCH2));

      // External faults; lowest terminal wins the indication
      ext_fault_d = 1'b0;
      ext_alarm_d = 1'b0;
      external_fault_indication_d = '0;
      fault_stop_d = difd_pkg::DIFD_STOP_RAMP;

      for (int t = `DIFD_NUM_TERM - 1; t >= 0; t--) begin
         code = fn_of(input_function_select, t);
         if (code >= `DIFD_FN_EXT_FAULT_LO && code <= `DIFD_FN_EXT_FAULT_HI) begin
            trip = code[`DIFD_EF_POL_BIT] ? !term_s[t] : term_s[t];
            if (code[`DIFD_EF_RUNONLY_BIT] && !drive_running) begin
               trip = 1'b0;
            end
            if (trip) begin
               external_fault_indication_d = 4'(t + 1);
               fault_stop_d = code[`DIFD_EF_STOP_LSB +: 2];
               if (code[`DIFD_EF_STOP_LSB +: 2] == difd_pkg::DIFD_STOP_ALARM) begin
                  ext_alarm_d = 1'b1;
               end else begin
                  ext_fault_d = 1'b1;
               end
            end
         end
      end

      // PID group
      pid_enable_d = pid_mode_select & !active(input_function_select, term_s, `DIFD_FN_PID_CANCEL);
      integ_reset_d = active(input_function_select, term_s, `DIFD_FN_INT_RESET);
      integ_hold_d = active(input_function_select, term_s, `DIFD_FN_INT_HOLD) & !integ_reset_d;
      soft_starter_bypass_d = active(input_function_select, term_s, `DIFD_FN_SFS_CANCEL);
      pid_invert_d = active(input_function_select, term_s, `DIFD_FN_PID_INVERT);

      // Ramp and preset selection
      ramp_set_d = {active(input_function_select, term_s, `DIFD_FN_ACC_SEL2),
                    active(input_function_select, term_s, `DIFD_FN_ACC_SEL1)};
      preset_speed_d = {active(input_function_select, term_s, `DIFD_FN_SPEED_SEL4),
                        active(input_function_select, term_s, `DIFD_FN_SPEED_SEL3),
                        active(input_function_select, term_s, `DIFD_FN_SPEED_SEL2),
                        active(input_function_select, term_s, `DIFD_FN_SPEED_SEL1)};

      // Two-wire sequences
      fwd = active(input_function_select, term_s, `DIFD_FN_FWD_RUN);
      rev = active(input_function_select, term_s, `DIFD_FN_REV_RUN);

      if (fwd && rev) begin
         run_cmd_d = 1'b0;
         reverse_d = reverse_q;
         ext_fault_d = 1'b1;
      end else if (fwd || rev) begin
         run_cmd_d = 1'b1;
         reverse_d = rev;
      end else begin
         run_cmd_d = active(input_function_select, term_s, `DIFD_FN_RUN2);
         reverse_d = active(input_function_select, term_s, `DIFD_FN_DIR2);
      end

      // Any fault except an alarm-only trip stops the run command
      if (ext_fault_d) begin
         run_cmd_d = 1'b0;
      end

      // DC braking: start when stopped, run or jog ends it
      if (run_cmd_d || jog_cmd) begin
         dc_brake_d = 1'b0;
      end else if (active(input_function_select, term_s, `DIFD_FN_DC_BRAKE) && !drive_running) begin
         dc_brake_d = 1'b1;
      end else begin
         dc_brake_d = dc_brake_q & active(input_function_select, term_s, `DIFD_FN_DC_BRAKE);
      end

      // Speed search start point, current detection only
      search_from_max_d = !search_method_select & active(input_function_select, term_s, `DIFD_FN_SEARCH1);
      search_from_ref_d = !search_method_select & active(input_function_select, term_s, `DIFD_FN_SEARCH2);

      // Frequency reference; sums wrap, limits are the ramp stage's job
      ref_sum = (sh_assigned && held_valid) ? held_ref : (sh_assigned ? '0 : base_ref);
      for (int k = 0; k < 3; k++) begin
         if (active(input_function_select, term_s, `DIFD_FN_OFFSET1 + `DIFD_FN_W'(k))) begin
            ref_sum = ref_sum + offset_frequency_values[k*`DIFD_FREQ_W +: `DIFD_FREQ_W];
         end
      end
      freq_ref_d = ref_sum;
   end

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         param_write_en_q <= 1'b0;
         config_conflict_error_q <= 1'b0;

         ext_fault_q <= 1'b0;
         ext_alarm_q <= 1'b0;
         external_fault_indication_q <= '0;
         fault_stop_q <= '0;

         pid_enable_q <= 1'b0;
         integ_reset_q <= 1'b0;
         integ_hold_q <= 1'b0;
         soft_starter_bypass_q <= 1'b0;
         pid_invert_q <= 1'b0;

         ramp_set_q <= '0;
         preset_speed_q <= '0;

         run_cmd_q <= 1'b0;
         reverse_q <= 1'b0;
         dc_brake_q <= 1'b0;

         search_from_max_q <= 1'b0;
         search_from_ref_q <= 1'b0;

         freq_ref_q <= '0;
      end else begin
         param_write_en_q <= param_write_en_d;
         config_conflict_error_q <= config_conflict_error_d;

         ext_fault_q <= ext_fault_d;
         ext_alarm_q <= ext_alarm_d;
         external_fault_indication_q <= external_fault_indication_d;
         fault_stop_q <= fault_stop_d;

         pid_enable_q <= pid_enable_d;
         integ_reset_q <= integ_reset_d;
         integ_hold_q <= integ_hold_d;
         soft_starter_bypass_q <= soft_starter_bypass_d;
         pid_invert_q <= pid_invert_d;

         ramp_set_q <= ramp_set_d;
         preset_speed_q <= preset_speed_d;

         run_cmd_q <= run_cmd_d;
         reverse_q <= reverse_d;
         dc_brake_q <= dc_brake_d;

         search_from_max_q <= search_from_max_d;
         search_from_ref_q <= search_from_ref_d;

         freq_ref_q <= freq_ref_d;
      end
   end
endmodule // difd_decoder

//--- sim/difd_contacts.sv
// External switch and contact model for the decoder terminals.
// Assumes the bench commands contact states; levels are 1 = closed.
`timescale 1ns/10ps
`include "difd_consts.svh"
module difd_contacts (
   // Clock used only to time contact movement
   input wire logic clock,
   // Commanded contact states
   input wire logic [`DIFD_NUM_TERM-1:0] close_cmd,
   // Contact levels at the terminals
   output logic [`DIFD_NUM_TERM-1:0] term_level
);
   // Contacts move off the clock edge, like a real switch
   initial term_level = '0;
   always @(posedge clock) begin
      term_level <= #7 close_cmd;
   end
endmodule // difd_contacts

//--- sim/difd_decoder_props.sv
// Concurrent checks on the input function decoder ports.
// Assumes terminal effects land 3 edges after a contact change.
`timescale 1ns/10ps
`include "difd_consts.svh"
module difd_decoder_props #(
   parameter logic [`DIFD_CNT_W-1:0] HOLD_CYCLES = `DIFD_CNT_W'(`DIFD_SH_CYCLES)
) (
   // Clock and reset
   input wire logic clock,
   input wire logic sys_rst,
   // Inputs watched
   input wire logic [`DIFD_NUM_TERM-1:0] term_in,
   input wire logic [`DIFD_NUM_TERM*`DIFD_FN_W-1:0] input_function_select,
   input wire logic jog_cmd,
   input wire logic search_method_select,
   input wire logic param_write_req,
   // Outputs watched
   input wire logic param_write_en_q,
   input wire logic config_conflict_error_q,
   input wire logic ext_fault_q,
   input wire logic ext_alarm_q,
   input wire logic [3:0] external_fault_indication_q,
   input wire logic [1:0] fault_stop_q,
   input wire logic run_cmd_q,
   input wire logic [1:0] ramp_set_q,
   input wire logic [3:0] preset_speed_q,
   input wire logic dc_brake_q,
   input wire logic search_from_max_q,
   input wire logic search_from_ref_q
);
   function automatic logic [6:0] fm(input logic [55:0] s, input logic [7:0] c);
      for (int t = 0; t < 7; t++) fm[t] = (s[8*t +: 8] == c);
   endfunction
   function automatic logic shx(input logic [55:0] s);
      shx = 1'b0;
      for (int t = 0; t < 7; t++) shx |= s[8*t +: 8] inside {8'h0A, 8'h10, 8'h11, 8'h44, 8'h45, 8'h46, 8'h75, 8'h76};
   endfunction
   // Pipeline holds reset values for three edges after release
   logic [2:0] rst_hist_q;
   always_ff @(posedge clock) rst_hist_q <= {rst_hist_q[1:0], sys_rst};
   wire logic settled = (rst_hist_q == 3'h0);
   wire logic [6:0] lock_m = fm(input_function_select, 8'h1B);
   wire logic [6:0] fwd_m = fm(input_function_select, 8'h40);
   wire logic [6:0] rev_m = fm(input_function_select, 8'h41);
   wire logic [6:0] acc2_m = fm(input_function_select, 8'h1A);
   wire logic [6:0] spd4_m = fm(input_function_select, 8'h32);
   wire logic sh_hit = |fm(input_function_select, 8'h1E) && shx(input_function_select);
   wire logic srch_hit = |fm(input_function_select, 8'h61) && |fm(input_function_select, 8'h62);
   default clocking cb @(posedge clock); endclocking
   default disable iff (sys_rst);
   lock_write_a: assert property (settled && |($past(lock_m) & ~$past(term_in, 3)) |-> !param_write_en_q)
      else $error("write allowed while locked");
   free_write_a: assert property (settled && $past(param_write_req) && $past(lock_m) == 7'h00 |-> param_write_en_q)
      else $error("write refused without lockout");
   sh_conflict_a: assert property (settled && $past(sh_hit) |-> config_conflict_error_q)
      else $error("sample hold conflict missed");
   srch_conflict_a: assert property (settled && $past(srch_hit) |-> config_conflict_error_q)
      else $error("search conflict missed");
   both_dir_a: assert property (settled && |($past(fwd_m) & $past(term_in, 3)) && |($past(rev_m) & $past(term_in, 3))
      |-> ext_fault_q && !run_cmd_q)
      else $error("both directions not faulted");
   indic_a: assert property (external_fault_indication_q != 4'h0
      |-> external_fault_indication_q <= 4'h7 && (ext_fault_q || ext_alarm_q))
      else $error("indication without trip");
   alarm_stop_a: assert property (external_fault_indication_q != 4'h0 && fault_stop_q == difd_pkg::DIFD_STOP_ALARM
      |-> ext_alarm_q)
      else $error("alarm code without alarm");
   fault_stop_a: assert property (external_fault_indication_q != 4'h0 && fault_stop_q != difd_pkg::DIFD_STOP_ALARM
      |-> ext_fault_q && !run_cmd_q)
      else $error("fault code without fault");
   ramp_sel_a: assert property (settled && $past(acc2_m) != 7'h00
      |-> ramp_set_q[1] == |($past(acc2_m) & $past(term_in, 3)))
      else $error("ramp select top bit wrong");
   speed_top_a: assert property (settled && $past(spd4_m) != 7'h00
      |-> preset_speed_q[3] == |($past(spd4_m) & $past(term_in, 3)))
      else $error("preset speed top bit wrong");
   jog_brake_a: assert property (settled && $past(jog_cmd) |-> !dc_brake_q)
      else $error("brake held during jog");
   search_mode_a: assert property (settled && $past(search_method_select) |-> !search_from_max_q && !search_from_ref_q)
      else $error("search outside current detection");
endmodule // difd_decoder_props

//--- sim/testbench.sv
// Self-checking bench for the input function decoder.
// Assumes decoder, synchroniser, sample/hold and package are compiled first.
`timescale 1ns/10ps
`include "difd_consts.svh"
module testbench;
   // Short hold keeps the run brief
   localparam logic [`DIFD_CNT_W-1:0] HOLD_CYCLES = 22'h00_0014;
   typedef struct packed {logic [55:0] s; logic [6:0] c; logic [16:0] e;} difd_row_t;
   logic clock = 1'b0;
   logic sys_rst = 1'b1;
   logic [6:0] cmd = 7'h00;
   logic [6:0] term_in;
   logic [55:0] sel = 56'h0;
   logic drive_running = 1'b0, pid_mode_select = 1'b0, jog_cmd = 1'b0;
   logic search_method_select = 1'b0, param_write_req = 1'b0;
   logic [15:0] analog_ref = 16'h1234, base_ref = 16'h0100;
   logic [47:0] offs = 48'h0200_0010_0001;
   logic param_write_en_q, config_conflict_error_q, ext_fault_q, ext_alarm_q, pid_enable_q;
   logic integ_reset_q, integ_hold_q, soft_starter_bypass_q, pid_invert_q, run_cmd_q, reverse_q;
   logic dc_brake_q, search_from_max_q, search_from_ref_q;
   logic [3:0] external_fault_indication_q, preset_speed_q;
   logic [1:0] fault_stop_q, ramp_set_q;
   logic [15:0] freq_ref_q;
   int n_mismatch = 0;
   int n_checks = 0;
   int n;
   logic trip;
   wire logic [16:0] row_seen = {config_conflict_error_q, ext_fault_q, ext_alarm_q, external_fault_indication_q,
      fault_stop_q, run_cmd_q, reverse_q, ramp_set_q, preset_speed_q};
   wire logic [55:0] pid_sel = {16'h0, 8'h35, 8'h34, 8'h31, 8'h30, 8'h19};
   logic [7:0] shx [8] = '{8'h0A, 8'h10, 8'h11, 8'h44, 8'h45, 8'h46, 8'h75, 8'h76};
   difd_row_t rows [11] = '{
      '{56'h0000_0000_0000_4140, 7'h01, 17'h0_0080}, '{56'h0000_0000_0000_4140, 7'h02, 17'h0_00C0},
      '{56'h0000_0000_0000_4140, 7'h00, 17'h0_0000}, '{56'h0000_0000_0000_4342, 7'h01, 17'h0_0080},
      '{56'h0000_0000_0000_4342, 7'h03, 17'h0_00C0}, '{56'h0000_0000_4342_4140, 7'h00, 17'h1_0000},
      '{56'h0000_0000_0000_6261, 7'h00, 17'h1_0000}, '{56'h0000_0000_0000_1A07, 7'h03, 17'h0_0030},
      '{56'h0000_0000_0000_1A07, 7'h02, 17'h0_0020}, '{56'h0000_0000_3205_0403, 7'h0F, 17'h0_000F},
      '{56'h0000_0000_3205_0403, 7'h08, 17'h0_0008}};
   always #25 clock = ~clock;
   difd_contacts u_contacts (.clock(clock), .close_cmd(cmd), .term_level(term_in));
   difd_decoder #(.HOLD_CYCLES(HOLD_CYCLES)) DUT (.clock(clock), .sys_rst(sys_rst), .term_in(term_in),
      .input_function_select(sel), .drive_running(drive_running), .pid_mode_select(pid_mode_select),
      .jog_cmd(jog_cmd), .search_method_select(search_method_select), .param_write_req(param_write_req),
      .analog_ref(analog_ref), .base_ref(base_ref), .offset_frequency_values(offs),
      .param_write_en_q(param_write_en_q), .config_conflict_error_q(config_conflict_error_q),
      .ext_fault_q(ext_fault_q), .ext_alarm_q(ext_alarm_q), .external_fault_indication_q(external_fault_indication_q),
      .fault_stop_q(fault_stop_q), .pid_enable_q(pid_enable_q), .integ_reset_q(integ_reset_q),
      .integ_hold_q(integ_hold_q), .soft_starter_bypass_q(soft_starter_bypass_q), .pid_invert_q(pid_invert_q),
      .ramp_set_q(ramp_set_q), .preset_speed_q(preset_speed_q), .run_cmd_q(run_cmd_q), .reverse_q(reverse_q),
      .dc_brake_q(dc_brake_q), .search_from_max_q(search_from_max_q), .search_from_ref_q(search_from_ref_q),
      .freq_ref_q(freq_ref_q));
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   // Five edges cover contact motion, two sync stages and the output register
   task automatic apply(input logic [55:0] s, input logic [6:0] c, input logic run);
      @(posedge clock);
      sel <= s;
      cmd <= c;
      drive_running <= run;
      repeat (5) @(posedge clock);
      #1;
   endtask
   task automatic pulse_reset;
      @(posedge clock);
      sys_rst <= 1'b1;
      repeat (3) @(posedge clock);
      sys_rst <= 1'b0;
   endtask
   task automatic complete_run;
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   initial begin
      repeat (3) @(posedge clock);
      sys_rst <= 1'b0;
      for (int i = 0; i < 11; i++) begin
         apply(rows[i].s, rows[i].c, 1'b0);
         check(row_seen, rows[i].e);
      end
      apply(56'h0000_0000_0000_4140, 7'h03, 1'b0);
      check({ext_fault_q, run_cmd_q}, 2'b10);
      // Terminal three carries each fault code, in tripping and idle contact states
      for (int k = 0; k < 16; k++) begin
         for (int r = 0; r < 2; r++) begin
            for (int p = 0; p < 2; p++) begin
               apply({32'h0, 8'h20 + 8'(k), 16'h0}, (k[0] ^ p[0]) ? 7'h00 : 7'h04, r[0]);
               trip = p == 0 && (r == 1 || k[1] == 1'b0);
               check({ext_fault_q, ext_alarm_q, external_fault_indication_q},
                  {trip && k < 12, trip && k >= 12, trip ? 4'h3 : 4'h0});
               if (trip) check(fault_stop_q, k[3:2]);
            end
         end
      end
      foreach (shx[i]) begin
         apply({40'h0, shx[i], 8'h1E}, 7'h00, 1'b0);
         check(config_conflict_error_q, 1'b1);
      end
      apply({40'h0, 8'h19, 8'h1E}, 7'h00, 1'b0);
      check(config_conflict_error_q, 1'b0);
      @(posedge clock) param_write_req <= 1'b1;
      apply({48'h0, 8'h1B}, 7'h00, 1'b0);
      check(param_write_en_q, 1'b0);
      apply({48'h0, 8'h1B}, 7'h01, 1'b0);
      check(param_write_en_q, 1'b1);
      @(posedge clock) param_write_req <= 1'b0;
      apply({48'h0, 8'h1E}, 7'h00, 1'b0);
      check({param_write_en_q, freq_ref_q}, 17'h0_0000);
      // A closure shorter than the hold time must be ignored
      apply({48'h0, 8'h1E}, 7'h01, 1'b0);
      apply({48'h0, 8'h1E}, 7'h00, 1'b0);
      check(freq_ref_q, 16'h0000);
      @(posedge clock);
      cmd <= 7'h01;
      n = 0;
      while (freq_ref_q !== 16'h1234 && n < 60) begin
         @(posedge clock) #1;
         n++;
      end
      check(n >= 20 && n < 30, 1'b1);
      if (n == 60) complete_run;
      @(posedge clock) analog_ref <= 16'h5555;
      apply({48'h0, 8'h1E}, 7'h00, 1'b0);
      check(freq_ref_q, 16'h1234);
      pulse_reset;
      apply({48'h0, 8'h1E}, 7'h00, 1'b0);
      check(freq_ref_q, 16'h0000);
      for (int c = 0; c < 8; c++) begin
         apply({32'h0, 8'h46, 8'h45, 8'h44}, 7'(c), 1'b0);
         check(freq_ref_q, base_ref + (c[0] ? offs[15:0] : 16'h0) + (c[1] ? offs[31:16] : 16'h0)
            + (c[2] ? offs[47:32] : 16'h0));
      end
      @(posedge clock) pid_mode_select <= 1'b1;
      apply(pid_sel, 7'h00, 1'b0);
      check({pid_enable_q, integ_reset_q, integ_hold_q, soft_starter_bypass_q, pid_invert_q}, 5'h10);
      apply(pid_sel, 7'h1F, 1'b0);
      check({pid_enable_q, integ_reset_q, integ_hold_q, soft_starter_bypass_q, pid_invert_q}, 5'h0B);
      apply(pid_sel, 7'h04, 1'b0);
      check({pid_enable_q, integ_reset_q, integ_hold_q, soft_starter_bypass_q, pid_invert_q}, 5'h14);
      apply({48'h0, 8'h60}, 7'h01, 1'b0);
      check(dc_brake_q, 1'b1);
      @(posedge clock) jog_cmd <= 1'b1;
      apply({48'h0, 8'h60}, 7'h01, 1'b1);
      check(dc_brake_q, 1'b0);
      @(posedge clock) jog_cmd <= 1'b0;
      apply({48'h0, 8'h60}, 7'h01, 1'b1);
      check(dc_brake_q, 1'b0);
      apply({48'h0, 8'h61}, 7'h01, 1'b0);
      check({search_from_max_q, search_from_ref_q}, 2'b10);
      apply({40'h0, 8'h62, 8'h00}, 7'h02, 1'b0);
      check({search_from_max_q, search_from_ref_q}, 2'b01);
      @(posedge clock) search_method_select <= 1'b1;
      apply({40'h0, 8'h62, 8'h00}, 7'h02, 1'b0);
      check({search_from_max_q, search_from_ref_q}, 2'b00);
      complete_run;
   end
endmodule // testbench
bind difd_decoder difd_decoder_props #(.HOLD_CYCLES(HOLD_CYCLES)) u_props (.clock(clock), .sys_rst(sys_rst),
   .term_in(term_in), .input_function_select(input_function_select), .jog_cmd(jog_cmd),
   .search_method_select(search_method_select), .param_write_req(param_write_req),
   .param_write_en_q(param_write_en_q), .config_conflict_error_q(config_conflict_error_q),
   .ext_fault_q(ext_fault_q), .ext_alarm_q(ext_alarm_q), .external_fault_indication_q(external_fault_indication_q),
   .fault_stop_q(fault_stop_q), .run_cmd_q(run_cmd_q), .ramp_set_q(ramp_set_q), .preset_speed_q(preset_speed_q),
   .dc_brake_q(dc_brake_q), .search_from_max_q(search_from_max_q), .search_from_ref_q(search_from_ref_q));
